// ### hdl/port_role_fault_control.v
// Control register bank for CC termination, orientation, test mode and fault enables.
`include "port_role_regs.vh"
module port_role_fault_control (
   input  wire       CLK_SYS,
   input  wire       RSTN,
   input  wire       WR_EN,
   input  wire       RD_EN,
   input  wire [7:0] ADDR,
   input  wire [7:0] WR_DATA,
   output reg  [7:0] RD_DATA,
   output reg        RD_VALID,
   input  wire       RX_MSG_ACCEPTED,
   output reg        GOODCRC_REQ,
   output reg        RX_ALERT,
   output reg        VCONN_CC1,
   output reg        VCONN_CC2,
   output reg        BMC_MONITOR_CC2,
   output reg        CC1_RA,
   output reg        CC1_RD,
   output reg  [1:0] CC1_RP,
   output reg        CC2_RA,
   output reg        CC2_RD,
   output reg  [1:0] CC2_RP,
   output reg        DUAL_ROLE_PHASE_SRC,
   output reg        DISCHARGE_TIMER_EN,
   output reg        DEBUG_OWNER_HOST
);
   wire [7:0] port_control;
   wire [7:0] role_control;
   wire [7:0] fault_control;
   wire [7:0] power_control;
   wire       cc1_ra;
   wire       cc1_rd;
   wire [1:0] cc1_rp;
   wire       cc2_ra;
   wire       cc2_rd;
   wire [1:0] cc2_rp;
   reg  [15:0] toggle_count_reg;
   reg         toggle_phase_reg;

   reg_field #(.RESET_VALUE(`PORT_CONTROL_RESET), .WRITE_MASK(`PORT_CONTROL_WMASK)) u_port (
      .clk     (CLK_SYS),
      .rst_n   (RSTN),
      .wr_en   (WR_EN && (ADDR == `PORT_CONTROL_ADDR)),
      .wr_data (WR_DATA),
      .value   (port_control)
   );
   reg_field #(.RESET_VALUE(`ROLE_CONTROL_RESET), .WRITE_MASK(`ROLE_CONTROL_WMASK)) u_role (
      .clk     (CLK_SYS),
      .rst_n   (RSTN),
      .wr_en   (WR_EN && (ADDR == `ROLE_CONTROL_ADDR)),
      .wr_data (WR_DATA),
      .value   (role_control)
   );
   reg_field #(.RESET_VALUE(`FAULT_CONTROL_RESET), .WRITE_MASK(`FAULT_CONTROL_WMASK)) u_fault (
      .clk     (CLK_SYS),
      .rst_n   (RSTN),
      .wr_en   (WR_EN && (ADDR == `FAULT_CONTROL_ADDR)),
      .wr_data (WR_DATA),
      .value   (fault_control)
   );
   reg_field #(.RESET_VALUE(`POWER_CONTROL_RESET), .WRITE_MASK(`POWER_CONTROL_WMASK)) u_power (
      .clk     (CLK_SYS),
      .rst_n   (RSTN),
      .wr_en   (WR_EN && (ADDR == `POWER_CONTROL_ADDR)),
      .wr_data (WR_DATA),
      .value   (power_control)
   );

   cc_line_drive u_cc1 (
      .term    (role_control[`ROLE_CC1_LSB+1:`ROLE_CC1_LSB]),
      .level   (role_control[`ROLE_LEVEL_LSB+1:`ROLE_LEVEL_LSB]),
      .pull_ra (cc1_ra),
      .pull_rd (cc1_rd),
      .pull_rp (cc1_rp)
   );
   cc_line_drive u_cc2 (
      .term    (role_control[`ROLE_CC2_LSB+1:`ROLE_CC2_LSB]),
      .level   (role_control[`ROLE_LEVEL_LSB+1:`ROLE_LEVEL_LSB]),
      .pull_ra (cc2_ra),
      .pull_rd (cc2_rd),
      .pull_rp (cc2_rp)
   );

   // Dual-role toggling alternates Rp and Rd on both lines at a fixed half period.
   always @(posedge CLK_SYS) begin
      if (!RSTN) begin
         toggle_count_reg <= 16'h0000;
         toggle_phase_reg <= 1'b0;
      end else if (!role_control[`ROLE_DUAL_BIT]) begin
         toggle_count_reg <= 16'h0000;
         toggle_phase_reg <= 1'b0;
      end else if (toggle_count_reg == `TOGGLE_HALF_LAST) begin
         toggle_count_reg <= 16'h0000;
         toggle_phase_reg <= ~toggle_phase_reg;
      end else begin
         toggle_count_reg <= toggle_count_reg + 16'h0001;
      end
   end

   always @(posedge CLK_SYS) begin
      if (!RSTN) begin
         RD_DATA             <= 8'h00;
         RD_VALID            <= 1'b0;
         GOODCRC_REQ         <= 1'b0;
         RX_ALERT            <= 1'b0;
         VCONN_CC1           <= 1'b0;
         VCONN_CC2           <= 1'b0;
         BMC_MONITOR_CC2     <= 1'b0;
         CC1_RA              <= 1'b0;
         CC1_RD              <= 1'b1;
         CC1_RP              <= 2'h0;
         CC2_RA              <= 1'b0;
         CC2_RD              <= 1'b1;
         CC2_RP              <= 2'h0;
         DUAL_ROLE_PHASE_SRC <= 1'b0;
         DISCHARGE_TIMER_EN  <= 1'b1;
         DEBUG_OWNER_HOST    <= 1'b0;
      end else begin
         RD_VALID <= RD_EN;
         if (!RD_EN) begin
            RD_DATA <= 8'h00;
         end else if (ADDR == `PORT_CONTROL_ADDR) begin
            RD_DATA <= port_control;
         end else if (ADDR == `ROLE_CONTROL_ADDR) begin
            RD_DATA <= role_control;
         end else if (ADDR == `FAULT_CONTROL_ADDR) begin
            RD_DATA <= fault_control;
         end else if (ADDR == `POWER_CONTROL_ADDR) begin
            RD_DATA <= power_control;
         end else begin
            RD_DATA <= 8'h00;
         end
         // Every accepted message is acknowledged; test mode only hides it from the host.
         GOODCRC_REQ <= RX_MSG_ACCEPTED;
         RX_ALERT    <= RX_MSG_ACCEPTED && !port_control[`PORT_TEST_BIT];
         VCONN_CC1   <= power_control[`POWER_CABLE_POWER_BIT] && port_control[`PORT_FLIP_BIT];
         VCONN_CC2   <= power_control[`POWER_CABLE_POWER_BIT] && !port_control[`PORT_FLIP_BIT];
         BMC_MONITOR_CC2 <= port_control[`PORT_FLIP_BIT];
         if (role_control[`ROLE_DUAL_BIT]) begin
            // Rp advertisement in the source phase uses the programmed level.
            CC1_RA <= 1'b0;
            CC2_RA <= 1'b0;
            CC1_RD <= !toggle_phase_reg;
            CC2_RD <= !toggle_phase_reg;
            CC1_RP <= toggle_phase_reg ? cc1_rp_level(role_control) : 2'h0;
            CC2_RP <= toggle_phase_reg ? cc1_rp_level(role_control) : 2'h0;
         end else begin
            CC1_RA <= cc1_ra;
            CC1_RD <= cc1_rd;
            CC1_RP <= cc1_rp;
            CC2_RA <= cc2_ra;
            CC2_RD <= cc2_rd;
            CC2_RP <= cc2_rp;
         end
         DUAL_ROLE_PHASE_SRC <= role_control[`ROLE_DUAL_BIT] && toggle_phase_reg;
         DISCHARGE_TIMER_EN  <= !fault_control[`FAULT_TIMER_OFF_BIT];
         // Owner flag is exported for completeness; this device takes no action on it.
         DEBUG_OWNER_HOST    <= port_control[`PORT_DEBUG_OWNER_BIT];
      end
   end

   // Rp code: 1 default, 2 for 1.5 A, 3 for 3 A; reserved level falls back to default.
   function [1:0] cc1_rp_level;
      input [7:0] role;
      begin
         if (role[`ROLE_LEVEL_LSB+1:`ROLE_LEVEL_LSB] == `LEVEL_RESERVED) begin
            cc1_rp_level = 2'h1;
         end else begin
            cc1_rp_level = role[`ROLE_LEVEL_LSB+1:`ROLE_LEVEL_LSB] + 2'h1;
         end
      end
   endfunction
endmodule // port_role_fault_control

// ### hdl/port_role_regs.vh
// Register offsets, field positions, reset values and the behaviour list for the CC control bank.
// Notes on behaviour
// - Port control at 0x19, resets 0x00, bits 7:5 read zero.
// - Debug indication owner bit 4 resets 0; host writes 1 to own it.
// - Stretch policy bits 3:2 read-only 00; serial clock is never stretched.
// - Test mode set: accepted messages get GoodCRC, no alert; clear: alert.
// - Orientation 0: VCONN on CC2, monitor CC1; 1: VCONN on CC1, monitor CC2.
// - Role control at 0x1A, resets 0x0A, bit 7 reads zero.
// - Dual-role 0: fields fix terminations; 1: port toggles as dual-role.
// - Pull-up level 00 default, 01 1.5 A, 10 3 A, 11 reserved.
// - Per-line field 00 Ra, 01 Rp, 10 Rd, 11 open; reset 10.
// - Fault control at 0x1B, resets 0x06, bits 7:5 read-only, bit 0 writable.
// - Shutoff block bit 4 resets 0, stored but has no effect.
// - Discharge timer bit 3: 0 enables timer, 1 disables it; resets 0.
// - Overcurrent guard bit 2 resets 1, stored but has no effect.
// - Overvoltage guard bit 1 resets 1, stored but has no effect.
// - Power control at 0x1C, resets 0x60.
// - Cable power bit sources VCONN onto the line chosen by orientation.
`ifndef PORT_ROLE_REGS_VH
`define PORT_ROLE_REGS_VH
`define PORT_CONTROL_ADDR       8'h19
`define ROLE_CONTROL_ADDR       8'h1A
`define FAULT_CONTROL_ADDR      8'h1B
`define POWER_CONTROL_ADDR      8'h1C
`define PORT_CONTROL_RESET      8'h00
`define ROLE_CONTROL_RESET      8'h0A
`define FAULT_CONTROL_RESET     8'h06
`define POWER_CONTROL_RESET     8'h60
`define PORT_CONTROL_WMASK      8'h13
`define ROLE_CONTROL_WMASK      8'h7F
`define FAULT_CONTROL_WMASK     8'h1F
`define POWER_CONTROL_WMASK     8'h7F
`define PORT_FLIP_BIT           0
`define PORT_TEST_BIT           1
`define PORT_DEBUG_OWNER_BIT    4
`define ROLE_CC1_LSB            0
`define ROLE_CC2_LSB            2
`define ROLE_LEVEL_LSB          4
`define ROLE_DUAL_BIT           6
`define FAULT_GUARD_OVP_BIT     1
`define FAULT_GUARD_OCP_BIT     2
`define FAULT_TIMER_OFF_BIT     3
`define FAULT_SHUTOFF_BIT       4
`define POWER_CABLE_POWER_BIT   0
`define TERM_RA                 2'h0
`define TERM_RP                 2'h1
`define TERM_RD                 2'h2
`define TERM_OPEN               2'h3
`define LEVEL_RESERVED          2'h3
`define TOGGLE_HALF_US          35
`define TOGGLE_HALF_CYCLES      ((`TOGGLE_HALF_US * 100) / 1)
`define TOGGLE_HALF_LAST        16'h0DAB
`endif

// ### hdl/reg_field.v
// One eight-bit control register with a write mask; masked bits hold their reset value.
`include "port_role_regs.vh"
module reg_field #(
   parameter [7:0] RESET_VALUE = 8'h00,
   parameter [7:0] WRITE_MASK  = 8'hFF
) (
   input  wire       clk,
   input  wire       rst_n,
   input  wire       wr_en,
   input  wire [7:0] wr_data,
   output reg  [7:0] value
);
   always @(posedge clk) begin
      if (!rst_n) begin
         value <= RESET_VALUE;
      end else if (wr_en) begin
         // Only writable bits change; fixed bits keep their reset value.
         value <= (wr_data & WRITE_MASK) | (RESET_VALUE & ~WRITE_MASK);
      end
   end
endmodule // reg_field

// ### hdl/cc_line_drive.v
// Termination decode for one CC line.
`include "port_role_regs.vh"
module cc_line_drive (
   input  wire [1:0] term,
   input  wire [1:0] level,
   output reg        pull_ra,
   output reg        pull_rd,
   output reg  [1:0] pull_rp
);
   always @* begin
      pull_ra = 1'b0;
      pull_rd = 1'b0;
      pull_rp = 2'h0;
      case (term)
         `TERM_RA: pull_ra = 1'b1;
         `TERM_RP: pull_rp = (level == `LEVEL_RESERVED) ? 2'h1 : level + 2'h1;
         `TERM_RD: pull_rd = 1'b1;
         default:  pull_ra = 1'b0;
      endcase
   end
endmodule // cc_line_drive

// ### verif/port_role_fault_control_props.sv
// Port-level assertions for the CC control register bank.
module port_role_fault_control_props (
   input wire logic       CLK_SYS,
   input wire logic       RSTN,
   input wire logic       WR_EN,
   input wire logic       RD_EN,
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WR_DATA,
   input wire logic [7:0] RD_DATA,
   input wire logic       RD_VALID,
   input wire logic       RX_MSG_ACCEPTED,
   input wire logic       GOODCRC_REQ,
   input wire logic       RX_ALERT,
   input wire logic       VCONN_CC1,
   input wire logic       VCONN_CC2,
   input wire logic       BMC_MONITOR_CC2,
   input wire logic       CC1_RA,
   input wire logic       CC1_RD,
   input wire logic       DISCHARGE_TIMER_EN
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RSTN);
   logic wr_flip;
   assign wr_flip = WR_DATA[0];
   property p_rd_valid; RD_EN |=> RD_VALID && !RD_DATA[7]; endproperty
   a_rd_valid: assert property (p_rd_valid) else $error("read without valid reply");
   property p_port_fixed;
      RD_VALID && $past(ADDR) == 8'h19 |-> RD_DATA[7:5] == 3'h0 && RD_DATA[3:2] == 2'h0;
   endproperty
   a_port_fixed: assert property (p_port_fixed) else $error("port fixed bits not zero");
   property p_fault_rsv; RD_VALID && $past(ADDR) == 8'h1B |-> RD_DATA[7:5] == 3'h0; endproperty
   a_fault_rsv: assert property (p_fault_rsv) else $error("fault top bits not zero");
   property p_crc; RX_MSG_ACCEPTED |=> GOODCRC_REQ; endproperty
   a_crc: assert property (p_crc) else $error("no reply request after message");
   property p_alert; RX_ALERT |-> GOODCRC_REQ && $past(RX_MSG_ACCEPTED); endproperty
   a_alert: assert property (p_alert) else $error("alert without message");
   property p_vconn1; VCONN_CC1 |-> BMC_MONITOR_CC2 && !VCONN_CC2; endproperty
   a_vconn1: assert property (p_vconn1) else $error("cable power on wrong line");
   property p_vconn2; VCONN_CC2 |-> !BMC_MONITOR_CC2; endproperty
   a_vconn2: assert property (p_vconn2) else $error("cable power on wrong line");
   property p_flip_wr; WR_EN && ADDR == 8'h19 |-> ##2 BMC_MONITOR_CC2 == $past(wr_flip, 2); endproperty
   a_flip_wr: assert property (p_flip_wr) else $error("monitor line not following write");
   property p_term; !(CC1_RA && CC1_RD); endproperty
   a_term: assert property (p_term) else $error("two terminations at once");
   property p_reset; $rose(RSTN) |-> CC1_RD && DISCHARGE_TIMER_EN; endproperty
   a_reset: assert property (p_reset) else $error("wrong state after reset");
   c_read: cover property (RD_VALID && $past(ADDR) == 8'h1A);
   c_alert: cover property (RX_ALERT);
   c_quiet: cover property (GOODCRC_REQ && !RX_ALERT);
endmodule // port_role_fault_control_props

bind port_role_fault_control port_role_fault_control_props i_props (.*);

// ### verif/port_host_model.sv
// Behavioural port manager driving the register strobes and receive pulses.
module port_host_model (
   input wire logic       clk,
   input wire logic [7:0] rd_data,
   output logic           wr_en,
   output logic           rd_en,
   output logic           rx_acc,
   output logic [7:0]     addr,
   output logic [7:0]     wr_data
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {wr_en, rd_en, rx_acc, addr, wr_data} = 19'h0;
   // Strobes last one edge; each task starts at a fresh edge, so none is driven twice at once.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      {wr_en, addr, wr_data} <= {1'b1, a, d};
      @(posedge clk);
      wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      {rd_en, addr} <= {1'b1, a};
      @(posedge clk);
      rd_en <= 1'b0;
      #1 d = rd_data;
   endtask
   task automatic rx;
      @(posedge clk);
      rx_acc <= 1'b1;
      @(posedge clk);
      rx_acc <= 1'b0;
      #1;
   endtask
endmodule // port_host_model

// ### verif/port_role_fault_control_bench.sv
// Self-checking bench for the CC control register bank.
module port_role_fault_control_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk = 1'b0, rst_n = 1'b0, wr_en, rd_en, rx_acc;
   logic [7:0] addr, wr_data, rd_data, got, d;
   logic       rd_valid, crc, alert, v1, v2, mon, c1ra, c1rd, c2ra, c2rd, dsrc, tmr, dbg;
   logic [1:0] c1rp, c2rp;
   logic [15:0] lf = 16'h5BD4;
   logic [7:0] mir [4] = '{8'h00, 8'h0A, 8'h06, 8'h60};
   int         fails = 0, total_checks = 0;
   always #5 clk = ~clk;
   port_host_model i_host (.clk(clk), .rd_data(rd_data), .wr_en(wr_en), .rd_en(rd_en),
      .rx_acc(rx_acc), .addr(addr), .wr_data(wr_data));
   port_role_fault_control i_dut (.CLK_SYS(clk), .RSTN(rst_n), .WR_EN(wr_en), .RD_EN(rd_en),
      .ADDR(addr), .WR_DATA(wr_data), .RD_DATA(rd_data), .RD_VALID(rd_valid),
      .RX_MSG_ACCEPTED(rx_acc), .GOODCRC_REQ(crc), .RX_ALERT(alert), .VCONN_CC1(v1),
      .VCONN_CC2(v2), .BMC_MONITOR_CC2(mon), .CC1_RA(c1ra), .CC1_RD(c1rd), .CC1_RP(c1rp),
      .CC2_RA(c2ra), .CC2_RD(c2rd), .CC2_RP(c2rp), .DUAL_ROLE_PHASE_SRC(dsrc),
      .DISCHARGE_TIMER_EN(tmr), .DEBUG_OWNER_HOST(dbg));
   function automatic logic [15:0] lfsr(input logic [15:0] x);
      lfsr = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   // Read-only bits keep their reset value, which the mirror already holds.
   function automatic logic [7:0] fix(input int i, input logic [7:0] v);
      logic [7:0] m;
      m = (i == 0) ? 8'h13 : (i == 2) ? 8'h1F : 8'h7F;
      fix = (v & m) | (mir[i] & ~m);
   endfunction
   function automatic logic [3:0] term(input logic [1:0] f, input logic [1:0] l);
      case (f)
         2'h0: term = 4'h8;
         2'h1: term = {2'h0, (l == 2'h2) ? 2'h3 : (l == 2'h1) ? 2'h2 : 2'h1};
         2'h2: term = 4'h4;
         default: term = 4'h0;
      endcase
   endfunction
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      total_checks++;
      if (g !== e) begin
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
         fails++;
      end
   endtask
   task automatic wrap_up;
      $display("checks=%0d fails=%0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic wreg(input int i, input logic [7:0] v);
      i_host.wr(8'h19 + i[7:0], v);
      mir[i] = fix(i, v);
   endtask
   task automatic rchk(input int i);
      i_host.rd(8'h19 + i[7:0], got);
      chk(got, mir[i]);
      chk({7'h00, rd_valid}, 8'h01);
   endtask
   task automatic outs;
      chk({3'h0, v1, v2, mon, tmr, dbg}, {3'h0, mir[3][0] & mir[0][0], mir[3][0] & ~mir[0][0],
         mir[0][0], ~mir[2][3], mir[0][4]});
      chk({c1ra, c1rd, c1rp, c2ra, c2rd, c2rp}, {term(mir[1][1:0], mir[1][5:4]),
         term(mir[1][3:2], mir[1][5:4])});
   endtask
   initial begin
      int n;
      int i;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      for (n = 0; n < 4; n++) rchk(n);
      i_host.rd(8'h1D, got);
      chk(got, 8'h00);
      $display("test reset values done");
      for (n = 0; n < 48; n++) begin
         lf = lfsr(lf);
         i = (n < 8) ? n % 4 : lf[1:0];
         d = (n < 4) ? 8'hFF : (n < 8) ? 8'h00 : lf[15:8];
         if (i == 1) d[6] = 1'b0;
         if (n == 20) i_host.wr(8'h18, 8'hFF);
         wreg(i, d);
         rchk(i);
         outs;
      end
      $display("test register access done");
      for (n = 0; n < 2; n++) begin
         wreg(0, {6'h0, n[0], 1'b0});
         i_host.rx;
         chk({6'h0, crc, alert}, {7'h01, ~n[0]});
      end
      wreg(0, 8'h00);
      $display("test receive done");
      wreg(1, 8'h40);
      repeat (2) @(posedge clk);
      #1 chk({6'h0, c1rd, dsrc}, 8'h02);
      repeat (3600) @(posedge clk);
      #1 chk({6'h0, c1rd, dsrc}, 8'h01);
      $display("test dual role done");
      wrap_up;
   end
   initial begin
      repeat (100000) @(posedge clk);
      fails++;
      wrap_up;
   end
endmodule // port_role_fault_control_bench
